//--- sest_core.sv
// Purpose: Symbol decision, midpoint error, rail combine, scale, buffer.
// Assumes: Samples arrive from logic on the same clock; no synchroniser.
// Notes: Register port is the device's destination-address write and read.
`timescale 1ns/1ps
`include "sest_defs.svh"

module sest_core
	import sest_pkg::*;
#(
	parameter int W  = `SEST_SAMP_W,  // Sample width
	parameter int OW = 12             // Loop filter input width
) (
	// Clock and reset
	input  wire logic                   i_clock,
	input  wire logic                   i_arst_n,
	// Configuration register port
	input  wire logic                   i_reg_wr,
	input  wire logic                   i_reg_rd,
	input  wire logic [`SEST_ADDR_W-1:0] i_reg_addr,
	input  wire logic [31:0]            i_reg_wdata,
	output logic      [31:0]            o_reg_rdata,
	// Sample stream in
	input  wire logic                   i_samp_valid,
	input  wire sest_samp_t             i_samp,
	output logic                        o_samp_ready,
	// Scaled error to loop filter
	output logic                        o_err_valid,
	output logic signed [OW-1:0]        o_err_data,
	input  wire logic                   i_err_ready
);
	localparam int EW = W + 2;  // Midpoint error width

	// Elaboration checks: struct width is fixed, output must fit the shifter
	if (W != `SEST_SAMP_W) begin : g_bad_w
		$error("sest_core: W must match sample struct");
	end
	if (OW < 2 || OW > EW + 4) begin : g_bad_ow
		$error("sest_core: bad OW");
	end

	// Configuration storage and decoded view
	logic [`SEST_USED_W-1:0] cfg_reg;   // Bits 15-0 of the register
	sest_cfg_t               cfg;       // Fields steering the datapath
	logic [2:0]              bits_ord;  // Log2 of the order

	// One driver for the whole view; fields sit in struct order, shift on top
	assign cfg = sest_cfg_t'(cfg_reg[`SEST_SHIFT_LSB+1:`SEST_RAIL_BIT]);
	assign bits_ord   = {1'b0, cfg.order} + 3'd1;

	// Decision index: top bits of the offset-binary sample
	function automatic logic [3:0] dec_idx(input logic signed [W-1:0] x,
	                                       input logic [2:0] b);
		logic [W-1:0] xu;
		xu = {~x[W-1], x[W-2:0]};  // Range -1..+1 mapped to 0..2^W-1
		dec_idx = 4'(xu >> (W - int'(b)));
	endfunction : dec_idx

	// Ideal level of a decision: centre of its slice
	function automatic logic signed [W:0] sym_val(input logic [3:0] k,
	                                              input logic [2:0] b);
		logic signed [W+1:0] t;
		t = (W+2)'({k, 1'b1}) <<< (W - 1 - int'(b));
		sym_val = (W+1)'(t - (W+2)'(1 <<< (W - 1)));
	endfunction : sym_val

	// Midpoint error: midpoint sample against mean of both neighbours
	function automatic logic signed [EW-1:0] mid_err(input logic signed [W-1:0] mid,
	                                                 input logic [3:0] kp,
	                                                 input logic [3:0] kc,
	                                                 input logic [2:0] b);
		logic signed [W+1:0] mean;
		mean = ((W+2)'(sym_val(kp, b)) + (W+2)'(sym_val(kc, b))) >>> 1;
		if (kp == kc) begin
			mid_err = '0;  // No transition, no timing information
		end else begin
			mid_err = EW'((W+2)'(mid) - mean);
		end
	endfunction : mid_err

	// Register write; upper half is not stored and reads as zero
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg_reg <= `SEST_CFG_RESET;
		end else if (i_reg_wr && i_reg_addr == `SEST_ADDR_CFG) begin
			cfg_reg <= i_reg_wdata[`SEST_USED_W-1:0];  // host keeps 15-13 zero
		end
	end

	// Register read; unmapped addresses return zero
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_reg_rdata <= 32'h0000_0000;
		end else if (i_reg_rd) begin
			o_reg_rdata <= (i_reg_addr == `SEST_ADDR_CFG) ? {16'h0000, cfg_reg} : 32'h0;
		end
	end

	// Per-sample decisions and errors
	logic                accept;        // Sample taken this cycle
	logic [3:0]          k_i;           // In-phase decision
	logic [3:0]          k_q;           // Quadrature decision
	logic [3:0]          k_i_prev_reg;  // Previous in-phase decision
	logic [3:0]          k_q_prev_reg;  // Previous quadrature decision
	logic signed [EW-1:0] err_i;        // In-phase midpoint error
	logic signed [EW-1:0] err_q;        // Quadrature midpoint error
	logic signed [EW-1:0] err_comb;     // Rails combined
	logic signed [EW:0]   err_sum;      // Dual-rail sum before halving
	logic signed [OW-1:0] err_scaled;   // After shift and clamp

	assign accept  = i_samp_valid && o_samp_ready;
	assign k_i     = dec_idx(i_samp.i_end, bits_ord);
	assign k_q     = dec_idx(i_samp.q_end, bits_ord);
	assign err_i   = mid_err(i_samp.i_mid, k_i_prev_reg, k_i, bits_ord);
	assign err_q   = mid_err(i_samp.q_mid, k_q_prev_reg, k_q, bits_ord);
	assign err_sum = (EW+1)'(err_i) + (EW+1)'(err_q);
	// Single rail drops the quadrature term entirely
	assign err_comb = cfg.single ? err_i : EW'(err_sum >>> 1);

	// Previous decisions, updated only on accepted samples
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			k_i_prev_reg <= 4'h0;
			k_q_prev_reg <= 4'h0;
		end else if (accept) begin
			k_i_prev_reg <= k_i;
			k_q_prev_reg <= k_q;
		end
	end

	// Scaler with saturation
	sest_shift_sat #(
		.IW (EW),
		.OW (OW)
	) u_shift (
		.i_err  (err_comb),
		.i_code (cfg.shift),
		.o_word (err_scaled)
	);

	// Two-entry skid buffer: output stage plus one spare
	logic                 skid_valid_reg;  // Spare entry occupied
	logic signed [OW-1:0] skid_data_reg;   // Spare entry word
	logic                 pop;             // Loop filter takes the head

	assign pop = o_err_valid && i_err_ready;

	// Output stage; refills from the spare first to keep order
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_err_valid <= 1'b0;
			o_err_data  <= '0;
		end else if (!o_err_valid || pop) begin
			if (skid_valid_reg) begin
				o_err_valid <= 1'b1;
				o_err_data  <= skid_data_reg;
			end else begin
				o_err_valid <= accept;
				o_err_data  <= accept ? err_scaled : o_err_data;
			end
		end
	end

	// Spare entry catches a word when the head is stalled
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			skid_valid_reg <= 1'b0;
			skid_data_reg  <= '0;
		end else if (skid_valid_reg) begin
			if (pop) begin
				skid_valid_reg <= 1'b0;  // Ready was low, nothing new enters
			end
		end else if (accept && o_err_valid && !pop) begin
			skid_valid_reg <= 1'b1;
			skid_data_reg  <= err_scaled;
		end
	end

	// Ready from a flop: low while the spare will hold a word
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_samp_ready <= 1'b1;
		end else if (skid_valid_reg) begin
			o_samp_ready <= pop;
		end else begin
			o_samp_ready <= !(accept && o_err_valid && !pop);
		end
	end

	// Checking helpers: reference product and slice bounds
	logic signed [EW+5:0] ref_prod;   // Error times power of two
	logic signed [EW+5:0] ref_max;    // Clamp high
	logic signed [W+1:0]  slice_d;    // Sample minus chosen level
	logic signed [W+1:0]  slice_h;    // Half slice width

	assign ref_prod = (EW+6)'(err_comb) * (EW+6)'(2 <<< cfg.shift);
	assign ref_max  = (EW+6)'((64'sd1 <<< (OW - 1)) - 64'sd1);
	assign slice_d  = (W+2)'(i_samp.i_end) - (W+2)'(sym_val(k_i, bits_ord));
	assign slice_h  = (W+2)'(1 <<< (W - 1 - int'(bits_ord)));

	sequence s_take;
		i_samp_valid && o_samp_ready;
	endsequence

	property p_scale;
		@(posedge i_clock) disable iff (!i_arst_n)
		(ref_prod <= ref_max && ref_prod >= -ref_max) |-> err_scaled == OW'(ref_prod);
	endproperty
	a_scale: assert property (p_scale) else $error("scaled error not a power-of-two multiple");

	property p_sat_hi;
		@(posedge i_clock) disable iff (!i_arst_n)
		ref_prod > ref_max |-> err_scaled == OW'(ref_max);
	endproperty
	a_sat_hi: assert property (p_sat_hi) else $error("positive overflow not clamped");

	property p_sat_lo;
		@(posedge i_clock) disable iff (!i_arst_n)
		ref_prod < -ref_max - 1 |-> err_scaled == OW'(-ref_max - 1);
	endproperty
	a_sat_lo: assert property (p_sat_lo) else $error("negative overflow not clamped");

	property p_order;
		@(posedge i_clock) disable iff (!i_arst_n)
		k_i == 4'((int'(i_samp.i_end) + (1 <<< (W - 1))) >>> (W - int'(bits_ord)));
	endproperty
	a_order: assert property (p_order) else $error("decision outside order range");

	property p_slice;
		@(posedge i_clock) disable iff (!i_arst_n)
		slice_d >= -slice_h && slice_d < slice_h;
	endproperty
	a_slice: assert property (p_slice) else $error("sample not nearest slice level");

	property p_prev;
		@(posedge i_clock) disable iff (!i_arst_n)
		s_take |=> k_i_prev_reg == $past(k_i) && k_q_prev_reg == $past(k_q);
	endproperty
	a_prev: assert property (p_prev) else $error("previous decision not kept");

	property p_rail;
		@(posedge i_clock) disable iff (!i_arst_n)
		cfg.single |-> err_comb == err_i;
	endproperty
	a_rail: assert property (p_rail) else $error("single rail uses quadrature");

	property p_dual;
		@(posedge i_clock) disable iff (!i_arst_n)
		!cfg.single |-> err_comb == EW'(((EW+1)'(err_i) + (EW+1)'(err_q)) >>> 1);
	endproperty
	a_dual: assert property (p_dual) else $error("dual rail not halved sum");

	property p_hold;
		@(posedge i_clock) disable iff (!i_arst_n)
		o_err_valid && !i_err_ready |=> o_err_valid && $stable(o_err_data);
	endproperty
	a_hold: assert property (p_hold) else $error("stalled error word changed");

endmodule : sest_core

//--- sest_defs.svh
// Purpose: Constants for the symbol sampling error scaler and slicer.
// Assumes: Included once per compile unit; bare name include.
// Notes: Offsets, field positions, reset values and widths live here.
// Notes on behaviour
// - Scale error by shift chosen by two-bit field
// - Codes 00..11 multiply by two through sixteen
// - Saturate shifted error instead of wrapping around
// - Order field picks two, four, eight, sixteen levels
// - End samples decide expected symbol for midpoint
// - Thresholds split minus one to one equally
// - Single rail nulls quadrature; dual sums, halves
`ifndef SEST_DEFS_SVH
`define SEST_DEFS_SVH

// Destination address of the configuration register
`define SEST_ADDR_CFG     5'h0e
`define SEST_ADDR_W       5
// Field positions inside the configuration word
`define SEST_SHIFT_LSB    11
`define SEST_ORDER_LSB    9
`define SEST_RAIL_BIT     8
`define SEST_USED_W       16
// Reset value of the configuration word
`define SEST_CFG_RESET    16'h0000
// Sample width of the matched filter rails
`define SEST_SAMP_W       10

`endif

//--- sest_pkg.sv
// Purpose: Types shared by the sampling error scaler files.
// Assumes: sest_defs.svh supplies the sample width.
// Notes: Sample bundle travels as one packed struct.
`include "sest_defs.svh"

package sest_pkg;

	// Modulation order codes
	typedef enum logic [1:0] {
		SEST_ORD_2  = 2'b00,
		SEST_ORD_4  = 2'b01,
		SEST_ORD_8  = 2'b10,
		SEST_ORD_16 = 2'b11
	} sest_order_t;

	// One symbol's matched filter samples on both rails
	typedef struct packed {
		logic signed [`SEST_SAMP_W-1:0] i_end;  // In-phase end-of-symbol
		logic signed [`SEST_SAMP_W-1:0] i_mid;  // In-phase transition midpoint
		logic signed [`SEST_SAMP_W-1:0] q_end;  // Quadrature end-of-symbol
		logic signed [`SEST_SAMP_W-1:0] q_mid;  // Quadrature transition midpoint
	} sest_samp_t;

	// Decoded configuration fields
	typedef struct packed {
		logic [1:0]  shift;   // Shift factor code
		sest_order_t order;   // Modulation order
		logic        single;  // Single rail select
	} sest_cfg_t;

endpackage : sest_pkg

//--- sest_shift_sat.sv
// Purpose: Left shift of the sampling error with saturation.
// Assumes: Pure combinational; caller registers the result.
// Notes: Shift is one to four places, clamp to output width extremes.
`timescale 1ns/1ps

module sest_shift_sat #(
	parameter int IW = 12,  // Input error width
	parameter int OW = 12   // Loop filter input width
) (
	// Error in
	input  wire logic signed [IW-1:0] i_err,
	input  wire logic        [1:0]    i_code,
	// Scaled error out
	output logic signed      [OW-1:0] o_word
);
	localparam int WW = IW + 4;  // Room for the largest shift

	logic signed [WW-1:0] wide;  // Shifted value, never wraps
	logic signed [WW-1:0] maxv;  // Most positive output value
	logic signed [WW-1:0] minv;  // Most negative output value

	// Refuse an output too narrow to sign or wider than the shifted word
	if (OW < 2 || OW > WW) begin : g_bad_ow
		$error("sest_shift_sat: bad OW");
	end

	// Shift then clamp; wide word keeps the sign so overflow is visible
	always_comb begin
		wide = WW'(i_err) <<< ({1'b0, i_code} + 3'd1);
		maxv = WW'((64'sd1 <<< (OW - 1)) - 64'sd1);
		minv = -maxv - WW'(1);
		if (wide > maxv) begin
			o_word = maxv[OW-1:0];
		end else if (wide < minv) begin
			o_word = minv[OW-1:0];
		end else begin
			o_word = wide[OW-1:0];
		end
	end

endmodule : sest_shift_sat

//--- sest_sink.sv
// Purpose: Loop filter stand-in that takes scaled error words.
// Assumes: Same clock as the block; ready moves at falling edges.
// Notes: Stall mode takes one word in three, so the block's buffer fills.
`timescale 1ns/1ps

module sest_sink (
	// Clock and mode
	input  wire logic               i_clock,
	input  wire logic               i_stall,
	// Error stream
	input  wire logic               i_valid,
	input  wire logic signed [11:0] i_data,
	output logic                    o_ready
);
	logic signed [11:0] got[$];  // Words taken, in order
	int                 cnt;     // Stall pattern phase

	// Ready before the first edge, so no word is taken blind
	initial begin
		cnt = 0;
		o_ready = 1'b1;
	end

	// Ready moves off the sampling edge
	always @(negedge i_clock) begin
		cnt++;
		o_ready <= !i_stall || (cnt % 3 == 0);
	end

	// A word counts only when both sides agree at the edge
	always @(posedge i_clock) begin
		if (i_valid && o_ready)
			got.push_back(i_data);
	end
endmodule : sest_sink

//--- test_symbol_error_scale_threshold.sv
// Purpose: Self-checking bench for the sampling error scaler.
// Assumes: Default widths W=10, OW=12; expectations rebuilt here.
// Notes: First word after a config write is not compared (history).
`timescale 1ns/1ps
`include "sest_defs.svh"

module test_symbol_error_scale_threshold;
	import sest_pkg::*;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end

	logic               clock, arst_n, reg_wr, reg_rd, samp_valid, samp_ready;
	logic               err_valid, err_ready, stall;
	logic [4:0]         reg_addr;   // Destination address
	logic [31:0]        reg_wdata, reg_rdata, w, rd;
	sest_samp_t         samp;       // Sample bundle
	logic signed [11:0] err_data;
	int                 miscompares, num_checks, sh, ord, sgl, kpi, kpq, skip;
	int                 exp_q[$];   // Expected words, 9999 marks skipped
	int ie_t[6] = '{-500, 450, -100, 300, 511, -512};
	int im_t[6] = '{200, -300, 37, -480, 505, -7};
	int qe_t[6] = '{400, -450, 120, -20, -300, 260};
	int qm_t[6] = '{-150, 90, -511, 333, 12, -260};

	sest_core uut (.i_clock(clock), .i_arst_n(arst_n), .i_reg_wr(reg_wr),
		.i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
		.o_reg_rdata(reg_rdata), .i_samp_valid(samp_valid), .i_samp(samp),
		.o_samp_ready(samp_ready), .o_err_valid(err_valid),
		.o_err_data(err_data), .i_err_ready(err_ready));
	sest_sink sink (.i_clock(clock), .i_stall(stall), .i_valid(err_valid),
		.i_data(err_data), .o_ready(err_ready));

	// 10 MHz clock
	always #50 clock = ~clock;

	// Level of decision index k with b bits per rail
	function automatic int lv(int k, int b);
		return (2 * k + 1) * (1 << (9 - b)) - 512;
	endfunction : lv

	task automatic reg_write(logic [4:0] a, logic [31:0] d);
		@(negedge clock);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask : reg_write

	task automatic reg_read(logic [4:0] a, output logic [31:0] d);
		@(negedge clock);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clock);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : reg_read

	// Offer one bundle, hold it until taken, then predict its word
	task automatic send(int ie, int im, int qe, int qm);
		int b, ki, kq, ei, eq, c, n;
		logic ok;
		@(negedge clock);
		samp_valid = 1'b1;
		samp = {10'(ie), 10'(im), 10'(qe), 10'(qm)};
		n = 0;
		do begin
			@(posedge clock);
			ok = samp_ready;
			n++;
		end while (!ok && n < 50);
		if (!ok)
			miscompares++;
		b = ord + 1;
		ki = (ie + 512) >>> (10 - b);
		kq = (qe + 512) >>> (10 - b);
		ei = (ki != kpi) ? im - ((lv(kpi, b) + lv(ki, b)) >>> 1) : 0;
		eq = (kq != kpq) ? qm - ((lv(kpq, b) + lv(kq, b)) >>> 1) : 0;
		c = sgl ? ei : (ei + eq) >>> 1;
		c = c <<< (sh + 1);
		c = (c > 2047) ? 2047 : (c < -2048) ? -2048 : c;
		exp_q.push_back(skip ? 9999 : c);
		skip = 0;
		kpi = ki;
		kpq = kq;
	endtask : send

	// Wait for every word, then compare in order
	task automatic check_out();
		int                 n, e;
		logic signed [11:0] g;   // Word the sink took
		n = 0;
		while (sink.got.size() < exp_q.size() && n < 200) begin
			@(posedge clock);
			n++;
		end
		`CHK("word count", exp_q.size(), sink.got.size())
		while (exp_q.size() > 0 && sink.got.size() > 0) begin
			e = exp_q.pop_front();
			g = sink.got.pop_front();  // Pop once; the compare may print it again
			if (e != 9999)
				`CHK("err_data", 12'(e), g)
		end
		exp_q.delete();
		sink.got.delete();
	endtask : check_out

	task automatic test_done();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	// Watchdog well beyond the expected run length
	initial begin
		repeat (30000) @(posedge clock);
		miscompares++;
		test_done();
	end

	// Main sequence
	initial begin
		{clock, reg_wr, reg_rd, samp_valid, stall} = '0;
		{reg_addr, reg_wdata, samp, miscompares, num_checks} = '0;
		arst_n = 1'b0;
		repeat (5) @(posedge clock);
		@(negedge clock);
		arst_n = 1'b1;
		reg_read(`SEST_ADDR_CFG, rd);
		`CHK("cfg reset", 32'h0000_0000, rd)
		reg_write(5'h0d, 32'hffff_ffff);
		reg_read(5'h0d, rd);
		`CHK("unmapped", 32'h0000_0000, rd)
		reg_read(`SEST_ADDR_CFG, rd);
		`CHK("cfg kept", 32'h0000_0000, rd)
		// Stall on the second pass fills the two-entry buffer
		for (int s = 0; s < 2; s++) begin
			stall = 1'(s);
			for (ord = 0; ord < 4; ord++) begin
				for (sh = 0; sh < 4; sh++) begin
					for (sgl = 0; sgl < 2; sgl++) begin
						w = {16'hffff, 3'b000, 2'(sh), 2'(ord), 1'(sgl), 8'h00};
						reg_write(`SEST_ADDR_CFG, w);
						reg_read(`SEST_ADDR_CFG, rd);
						`CHK("cfg readback", {16'h0000, w[15:0]}, rd)
						skip = 1;
						for (int i = 0; i < 6; i++)
							send(ie_t[i], im_t[i], qe_t[i], qm_t[i]);
						@(negedge clock);
						samp_valid = 1'b0;
						check_out();
					end
				end
			end
		end
		test_done();
	end
endmodule : test_symbol_error_scale_threshold
